// File: rtl/fws_pkg.sv
package fws_pkg;

    localparam int ADDR_W = 21;
    localparam int DATA_W = 16;

    // Data line positions of the status bits
    localparam int POLL_BIT    = 7;
    localparam int TOGGLE_BIT  = 6;
    localparam int TIMEOUT_BIT = 5;
    localparam int SECTOR_BIT  = 2;

    // Read and write cycle timing, 200 MHz clock
    localparam int CLK_PERIOD_PS  = 5000;
    localparam int READ_ACCESS_NS = 120;
    localparam int READ_CYCLES    = (READ_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int GAP_NS         = 20;
    localparam int GAP_CYCLES     = (GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WRITE_NS       = 50;
    localparam int WRITE_CYCLES   = (WRITE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W          = 8;

    // Reset command written to the device on failure
    localparam logic [DATA_W-1:0] RESET_CMD = 16'h00F0;

    typedef enum logic [1:0] {
        FWS_MODE_POLL   = 2'h0,
        FWS_MODE_TOGGLE = 2'h1
    } fws_mode_type;

    typedef enum logic [1:0] {
        FWS_RES_NONE = 2'h0,
        FWS_RES_DONE = 2'h1,
        FWS_RES_FAIL = 2'h2
    } fws_result_type;

    typedef struct packed {
        logic                  ce_n;
        logic                  oe_n;
        logic                  we_n;
        logic [ADDR_W-1:0]     addr;
        logic [DATA_W-1:0]     dout;
        logic                  dout_en_n;
    } fws_bus_type;

endpackage

// File: rtl/fws_host.sv
// Rules this block works with
// (R1) Poll bit may turn to true data before other lines; final read needs all lines.
// (R2) After seeing timeout flag at 1, read the poll bit once more.
// (R3) Poll at the valid poll address given by the user.
// (R4) Device ready/busy is open drain; host only samples it.
// (R5) Ready/busy low while programming or erasing, high otherwise.
// (R6) Ready/busy valid from last command write rising edge.
// (R7) Toggle bit readable at any address after last command write.
// (R8) Toggle bit inverts on each read during an operation.
// (R9) Toggle bit stops in erase suspend, toggles in suspend program.
// (R10) All-protected erase toggles about 1.8us, then array reads.
// (R11) Protected program toggles about 250ns, then array reads.
// (R12) Partly protected erase skips protected sectors.
// (R13) Sector toggle bit inverts on reads inside erasing sectors.
// (R14) Host combines toggle and sector toggle bits, or uses poll bit.
// (R15) Toggle check begins with two full reads; equal toggle means done.
// (R16) Still toggling with timeout flag high: recheck, then fail and reset.
// (R17) Leaving monitoring means restarting from the first double read.
// (R18) Timeout flag 1 means pulse-count limit exceeded.
// (R19) Program of 0 to 1 halts; timeout flag follows.
// (R20) After a failure, write the reset command.
// (R21) Programming shows inverted bit on poll bit until done.
// (R22) Erase shows 0 on poll bit, 1 once done or suspended.
// (R23) Toggle bits advance once per completed read cycle.
`timescale 1ns/1ps
module fws_host (
    input  wire logic                          clock,
    input  wire logic                          srst,
    input  wire logic                          start,
    input  wire fws_pkg::fws_mode_type         mode,
    input  wire logic                          is_erase,
    input  wire logic [fws_pkg::ADDR_W-1:0]    poll_addr,
    input  wire logic                          expect_bit,
    input  wire logic                          abandon,
    output logic                               busy,
    output fws_pkg::fws_result_type            result,
    output logic                               result_valid,
    output logic [fws_pkg::DATA_W-1:0]         final_data,
    output logic                               sector_toggling,
    output logic                               dev_ready,
    output fws_pkg::fws_bus_type               bus,
    input  wire logic [fws_pkg::DATA_W-1:0]    data_in,
    input  wire logic                          ready_busy_out
);

    typedef enum logic [6:0] {
        FWS_IDLE  = 7'h01,
        FWS_READ  = 7'h02,
        FWS_GAP   = 7'h04,
        FWS_EVAL  = 7'h08,
        FWS_WRITE = 7'h10,
        FWS_WREC  = 7'h20,
        FWS_DONE  = 7'h40
    } fws_state_type;

    fws_state_type              state;
    fws_state_type              next_state;
    logic [fws_pkg::CNT_W-1:0]  cnt;
    logic [fws_pkg::DATA_W-1:0] sample;
    logic [fws_pkg::DATA_W-1:0] prev;
    logic [1:0]                 nreads;
    logic                       recheck;
    logic                       fail_pend;
    fws_pkg::fws_mode_type      mode_q;
    logic                       erase_q;
    logic                       expect_q;
    logic [fws_pkg::ADDR_W-1:0] addr_q;

    function automatic logic toggled(input logic [fws_pkg::DATA_W-1:0] a, input logic [fws_pkg::DATA_W-1:0] b);
        toggled = a[fws_pkg::TOGGLE_BIT] ^ b[fws_pkg::TOGGLE_BIT];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    wire cnt_done   = (cnt == '0);
    wire tgl        = toggled(sample, prev);
    wire to_flag    = sample[fws_pkg::TIMEOUT_BIT];
    // Erase polls for 1, program for the written bit
    wire poll_want  = erase_q ? 1'b1 : expect_q;                               // [R21] [R22]
    wire poll_match = (sample[fws_pkg::POLL_BIT] == poll_want);
    wire is_toggle  = (mode_q == fws_pkg::FWS_MODE_TOGGLE);

    // Evaluate one completed read; decision codes: 0 read again, 1 done, 2 fail
    logic [1:0] decision;
    always_comb begin
        decision = 2'd0;
        if (is_toggle) begin
            if (nreads < 2'd2) begin                                           // [R15]
                decision = 2'd0;
            end else if (!tgl) begin
                decision = 2'd1;                                               // [R15]
            end else if (recheck) begin
                decision = 2'd2;                                               // [R16]
            end
        end else begin
            // Poll bit alone may settle early; a further full read follows
            if (poll_match && !recheck) begin
                decision = 2'd0;                                               // [R1]
            end else if (poll_match) begin
                decision = 2'd1;
            end else if (to_flag && recheck) begin
                decision = 2'd2;                                               // [R2] [R18]
            end
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            FWS_IDLE:  if (start) next_state = FWS_READ;
            FWS_READ:  if (cnt_done) next_state = FWS_GAP;
            FWS_GAP:   if (cnt_done) next_state = FWS_EVAL;
            FWS_EVAL: begin
                if (abandon) next_state = FWS_IDLE;                            // [R17]
                else if (decision == 2'd1) next_state = FWS_DONE;
                else if (decision == 2'd2) next_state = FWS_WRITE;             // [R20]
                else next_state = FWS_READ;
            end
            FWS_WRITE: if (cnt_done) next_state = FWS_WREC;
            FWS_WREC:  if (cnt_done) next_state = FWS_DONE;
            FWS_DONE:  next_state = FWS_IDLE;
            default:   next_state = FWS_IDLE;
        endcase
    end

    wire [fws_pkg::CNT_W-1:0] read_cnt  = fws_pkg::CNT_W'(fws_pkg::READ_CYCLES - 1);
    wire [fws_pkg::CNT_W-1:0] gap_cnt   = fws_pkg::CNT_W'(fws_pkg::GAP_CYCLES - 1);
    wire [fws_pkg::CNT_W-1:0] write_cnt = fws_pkg::CNT_W'(fws_pkg::WRITE_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock) begin
        if (srst) begin
            state <= FWS_IDLE;
            cnt   <= '0;
        end else begin
            state <= next_state;
            if (next_state != state || state == FWS_EVAL) begin
                case (next_state)
                    FWS_READ:  cnt <= read_cnt;
                    FWS_GAP:   cnt <= gap_cnt;
                    FWS_WRITE: cnt <= write_cnt;
                    FWS_WREC:  cnt <= gap_cnt;
                    default:   cnt <= '0;
                endcase
            end else if (!cnt_done) begin
                cnt <= cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            mode_q   <= fws_pkg::FWS_MODE_POLL;
            erase_q  <= 1'b0;
            expect_q <= 1'b0;
            addr_q   <= '0;
        end else if (state == FWS_IDLE && start) begin
            mode_q   <= mode;
            erase_q  <= is_erase;
            expect_q <= expect_bit;
            addr_q   <= poll_addr;                                             // [R3]
        end
    end

    // Sample at end of access; each read ends with chip/output enable release
    always_ff @(posedge clock) begin
        if (srst) begin
            sample <= '0;
            prev   <= '0;
            nreads <= 2'd0;
        end else if (state == FWS_IDLE || (state == FWS_EVAL && abandon)) begin
            // Cleared on the way out so a restart never reuses an old read
            nreads <= 2'd0;                                                    // [R17]
        end else if (state == FWS_READ && cnt_done) begin
            prev   <= sample;
            sample <= data_in;                                                 // [R23]
            if (nreads != 2'd2) nreads <= nreads + 2'd1;
        end
    end

    // Timeout seen with no settle, or poll bit matched in poll mode: one more read decides
    always_ff @(posedge clock) begin
        if (srst) begin
            recheck <= 1'b0;
        end else if (state == FWS_IDLE) begin
            recheck <= 1'b0;
        end else if (state == FWS_EVAL) begin
            if (is_toggle) recheck <= (nreads == 2'd2) && tgl && to_flag;      // [R16]
            else recheck <= poll_match || to_flag;                             // [R2]
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            fail_pend       <= 1'b0;
            result          <= fws_pkg::FWS_RES_NONE;
            result_valid    <= 1'b0;
            final_data      <= '0;
            sector_toggling <= 1'b0;
            dev_ready       <= 1'b0;
        end else begin
            dev_ready    <= ready_busy_out;                                    // [R4] [R5] [R6]
            result_valid <= (state == FWS_DONE);
            if (state == FWS_IDLE && start) fail_pend <= 1'b0;
            if (state == FWS_EVAL && decision == 2'd2) fail_pend <= 1'b1;
            if (state == FWS_EVAL && nreads == 2'd2) begin
                sector_toggling <= sample[fws_pkg::SECTOR_BIT] ^ prev[fws_pkg::SECTOR_BIT]; // [R13] [R14]
            end
            if (state == FWS_DONE) begin
                result     <= fail_pend ? fws_pkg::FWS_RES_FAIL : fws_pkg::FWS_RES_DONE;
                final_data <= sample;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus drive: data lines driven only for the reset command write
    always_ff @(posedge clock) begin
        if (srst) begin
            bus <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dout: '0, dout_en_n: 1'b1};
        end else begin
            // Chip enable held through recovery so the write latches on write enable rise
            bus.ce_n      <= !(next_state == FWS_READ || next_state == FWS_WRITE || next_state == FWS_WREC);
            bus.oe_n      <= !(next_state == FWS_READ);
            bus.we_n      <= !(next_state == FWS_WRITE);                       // [R20]
            bus.addr      <= addr_q;
            bus.dout      <= fws_pkg::RESET_CMD;
            bus.dout_en_n <= !(next_state == FWS_WRITE || next_state == FWS_WREC);
        end
    end

    assign busy = (state != FWS_IDLE);

    ////////////////////////////////////////////////////////////////////////
    sequence s_fail_eval;
        state == FWS_EVAL && decision == 2'd2 && !abandon;
    endsequence

    chk_fail_writes_reset: assert property (@(posedge clock) disable iff (srst) // [R20]
        s_fail_eval |=> (state == FWS_WRITE) ##1 (!bus.we_n && bus.dout == fws_pkg::RESET_CMD))
        else $error("failure did not issue reset command");

    chk_toggle_two_reads: assert property (@(posedge clock) disable iff (srst) // [R15]
        (state == FWS_EVAL && is_toggle && nreads < 2'd2 && !abandon) |=> state == FWS_READ)
        else $error("toggle check ended before two reads");

    chk_poll_recheck: assert property (@(posedge clock) disable iff (srst) // [R2]
        (state == FWS_EVAL && !is_toggle && !recheck && !abandon) |=> state == FWS_READ)
        else $error("poll decided without rechecking");

    chk_abandon_restart: assert property (@(posedge clock) disable iff (srst) // [R17]
        (state == FWS_EVAL && abandon) |=> (state == FWS_IDLE && nreads == 2'd0))
        else $error("abandon did not restart check");

    chk_read_strobe: assert property (@(posedge clock) disable iff (srst) // [R23]
        $rose(state == FWS_READ) |=> (!bus.oe_n && !bus.ce_n))
        else $error("read cycle without enables");

    chk_done_result: assert property (@(posedge clock) disable iff (srst) // [R16]
        (state == FWS_DONE && fail_pend) |=> (result == fws_pkg::FWS_RES_FAIL && result_valid))
        else $error("failure not reported");

    chk_toggle_done: assert property (@(posedge clock) disable iff (srst) // [R15]
        (state == FWS_EVAL && is_toggle && nreads == 2'd2 && !tgl && !abandon) |=> state == FWS_DONE)
        else $error("settled toggle not reported done");

    chk_write_ce_hold: assert property (@(posedge clock) disable iff (srst) // [R20]
        $rose(bus.we_n) |-> (!bus.ce_n && !bus.dout_en_n))
        else $error("write enable rose without chip enable or data");

    chk_ready_follow: assert property (@(posedge clock) disable iff (srst) // [R5]
        1'b1 |=> dev_ready == $past(ready_busy_out))
        else $error("ready flag does not follow pin");

endmodule

// File: bench/fws_flash_model.sv
`timescale 1ns/1ps
module fws_flash_model (
    input  wire fws_pkg::fws_bus_type             bus,
    input  wire logic                             arm,
    input  wire logic [7:0]                       cfg_reads,
    input  wire logic                             cfg_erase,
    input  wire logic                             cfg_fail,
    input  wire logic [fws_pkg::DATA_W-1:0]       cfg_word,
    output logic [fws_pkg::DATA_W-1:0]            data_out,
    output logic                                  busy_low
);
    int                          remaining = 0;
    logic                        erasing   = 1'b0;
    logic                        failed    = 1'b0;
    logic                        tgl       = 1'b0;
    logic                        sec       = 1'b0;
    logic [fws_pkg::DATA_W-1:0]  status;
    logic [fws_pkg::DATA_W-1:0]  last_out  = '0;
    wire                         reading   = !bus.ce_n && !bus.oe_n;
    wire                         in_op     = (remaining > 0) || failed;
    wire  [fws_pkg::DATA_W-1:0]  live      = in_op ? status : cfg_word;

    always_comb begin
        status = '0;
        status[fws_pkg::POLL_BIT] = erasing ? 1'b0 : ~cfg_word[fws_pkg::POLL_BIT];
        if (remaining == 1 && !failed) begin
            // Poll line turns true one read early
            status[fws_pkg::POLL_BIT] = cfg_word[fws_pkg::POLL_BIT];
        end
        status[fws_pkg::TOGGLE_BIT]  = tgl;
        status[fws_pkg::TIMEOUT_BIT] = failed;
        status[fws_pkg::SECTOR_BIT]  = erasing & sec;
    end

    ////////////////////////////////////////////////////////////////////////
    // Released lines show the inverse, so stale data never looks valid
    always @(live or reading) if (reading) last_out = live;
    assign data_out = reading ? live : ~last_out;
    assign busy_low = in_op;

    // One process owns the operation state, so each variable has one writer
    logic                        arm_was   = 1'b0;
    logic                        rd_was    = 1'b0;
    logic                        we_was    = 1'b1;

    always @(arm or reading or bus.we_n) begin
        if (arm && !arm_was) begin
            remaining = cfg_reads;
            erasing   = cfg_erase;
            failed    = cfg_fail;
            tgl       = 1'b0;
            sec       = 1'b0;
        end else if (!reading && rd_was && in_op) begin
            tgl = ~tgl;
            sec = ~sec;
            if (!failed) remaining = remaining - 1;
        end else if (bus.we_n && !we_was && !bus.ce_n && !bus.dout_en_n && bus.dout == fws_pkg::RESET_CMD) begin
            failed    = 1'b0;
            remaining = 0;
        end
        arm_was = arm;
        rd_was  = reading;
        we_was  = bus.we_n;
    end
endmodule

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic                            clock = 1'b0;
    logic                            srst = 1'b1;
    logic                            start = 1'b0;
    fws_pkg::fws_mode_type           mode = fws_pkg::FWS_MODE_POLL;
    logic                            is_erase = 1'b0;
    logic [fws_pkg::ADDR_W-1:0]      poll_addr = '0;
    logic                            expect_bit = 1'b0;
    logic                            abandon = 1'b0;
    logic                            busy, result_valid, sector_toggling, dev_ready, busy_low;
    fws_pkg::fws_result_type         result;
    logic [fws_pkg::DATA_W-1:0]      final_data, dev_data, cfg_word = '0;
    fws_pkg::fws_bus_type            bus;
    logic                            arm = 1'b0, cfg_erase = 1'b0, cfg_fail = 1'b0;
    logic [7:0]                      cfg_reads = '0;
    int                              failures = 0, num_checks = 0, cycles = 0, seed = 57498, k;
    wire  [fws_pkg::DATA_W-1:0]      data_in = !bus.dout_en_n ? bus.dout : dev_data;
    wire                             ready_busy_out = busy_low ? 1'b0 : 1'b1;

    fws_host fws_host_inst (.clock(clock), .srst(srst), .start(start), .mode(mode), .is_erase(is_erase),
        .poll_addr(poll_addr), .expect_bit(expect_bit), .abandon(abandon), .busy(busy), .result(result),
        .result_valid(result_valid), .final_data(final_data), .sector_toggling(sector_toggling),
        .dev_ready(dev_ready), .bus(bus), .data_in(data_in), .ready_busy_out(ready_busy_out));
    fws_flash_model fws_flash_model_inst (.bus(bus), .arm(arm), .cfg_reads(cfg_reads), .cfg_erase(cfg_erase),
        .cfg_fail(cfg_fail), .cfg_word(cfg_word), .data_out(dev_data), .busy_low(busy_low));

    initial forever #2.5 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [1:0] exp_result(input logic f);
        return f ? fws_pkg::FWS_RES_FAIL : fws_pkg::FWS_RES_DONE;
    endfunction

    task automatic run_check(input logic m, input logic e, input logic [7:0] n, input logic f,
                             input logic [15:0] w, input logic [20:0] a);
        int i;
        @(negedge clock);
        cfg_reads  = n;
        cfg_erase  = e;
        cfg_fail   = f;
        cfg_word   = e ? 16'hFFFF : w;
        mode       = m ? fws_pkg::FWS_MODE_TOGGLE : fws_pkg::FWS_MODE_POLL;
        is_erase   = e;
        expect_bit = cfg_word[7];
        poll_addr  = a;
        arm        = 1'b1;
        start      = 1'b1;
        @(negedge clock);
        arm   = 1'b0;
        start = 1'b0;
        if (n >= 5 && !f) begin
            repeat (100) @(negedge clock);
            chk(dev_ready, 1'b0);
            chk(sector_toggling, e);
            if (!bus.ce_n) chk(bus.addr, a);
        end
        for (i = 0; i < 20000 && result_valid !== 1'b1; i++) @(negedge clock);
        chk(result_valid, 1'b1);
        chk(result, exp_result(f));
        if (!f) chk(final_data, cfg_word);
        repeat (3) @(negedge clock);
        chk(dev_ready, 1'b1);
        chk(busy, 1'b0);
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 100000) begin
            failures++;
            complete_run();
        end
    end

    initial begin
        repeat (16) @(negedge clock);
        srst = 1'b0;
        chk({busy, result, bus.ce_n, bus.dout_en_n}, 5'h03);
        run_check(1'b0, 1'b0, 8'h01, 1'b0, 16'h1234, 21'h00ABC);
        run_check(1'b0, 1'b1, 8'h00, 1'b1, 16'h0000, 21'h10000);
        run_check(1'b1, 1'b0, 8'h03, 1'b1, 16'h5A5A, 21'h00010);
        run_check(1'b1, 1'b1, 8'h00, 1'b0, 16'h0000, 21'h1FFFF);
        run_check(1'b1, 1'b1, 8'h09, 1'b0, 16'h0000, 21'h05000);
        run_check(1'b0, 1'b0, 8'h06, 1'b0, 16'h00FF, 21'h00001);
        @(negedge clock);
        cfg_reads = 8'h30;
        mode      = fws_pkg::FWS_MODE_TOGGLE;
        arm       = 1'b1;
        start     = 1'b1;
        @(negedge clock);
        arm   = 1'b0;
        start = 1'b0;
        repeat (80) @(negedge clock);
        abandon = 1'b1;
        for (k = 0; k < 100 && busy !== 1'b0; k++) @(negedge clock);
        chk(busy, 1'b0);
        abandon = 1'b0;
        run_check(1'b1, 1'b0, 8'h05, 1'b0, 16'h0F0F, 21'h00222);
        for (k = 0; k < 14; k++) begin
            run_check(1'($random(seed) & 1), 1'($random(seed) & 1), 8'($random(seed) & 7),
                      ($random(seed) & 3) == 0, 16'($random(seed)), 21'($random(seed)));
        end
        complete_run();
    end
endmodule
